// ---- rtl/bundle_cfg_pkg.sv ----
// Package: offsets, field layout and encodings of the bundle configuration table
// Assumes a byte-addressed engine register space with 32-bit aligned words
package bundle_cfg_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [15:0] TABLE_BASE = 16'h8000;
    localparam logic [15:0] TABLE_SPAN = 16'h0500;
    localparam logic [15:0] WORD_STRIDE = 16'h0100;
    localparam logic [15:0] IDENT_WORD_OFS = 16'h0000;
    localparam logic [15:0] CONTROL_WORD_OFS = 16'h0100;
    localparam int BUNDLES = 64;
    localparam int WORDS_PER_BUNDLE = 5;
    localparam int ENTRY_BITS = 160;
    localparam int BUNDLE_W = 6;
    localparam int WORD_SEL_LSB = 8;
    localparam int WORD_SEL_W = 3;
    localparam int BUNDLE_LSB = 2;

    // ------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------
    localparam int JBUF_MSB = 31;
    localparam int JBUF_LSB = 22;
    localparam int PTYPE_MSB = 21;
    localparam int PTYPE_LSB = 20;
    localparam int RTP_BIT = 19;
    localparam int CW_BIT = 18;
    localparam int DEST_MSB = 17;
    localparam int DEST_LSB = 16;
    localparam int LOST_MSB = 15;
    localparam int LOST_LSB = 9;
    localparam int TS_MSB = 8;
    localparam int TS_LSB = 4;
    localparam int KEEP_BAD_BIT = 3;
    localparam int HDR_MSB = 2;
    localparam int HDR_LSB = 1;
    localparam int RBIT_BIT = 0;

    // ------------------------------------------------------------
    // Encodings and units
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAY_HDLC = 2'h0,
        PAY_AAL1 = 2'h1,
        PAY_RSVD = 2'h2,
        PAY_SATOP = 2'h3
    } payload_kind_t;

    typedef enum logic [1:0] {
        DST_RSVD = 2'h0,
        DST_ETH = 2'h1,
        DST_CPU = 2'h2,
        DST_TDM = 2'h3
    } dest_t;

    typedef enum logic [1:0] {
        HDR_MPLS = 2'h0,
        HDR_UDP_IP = 2'h1,
        HDR_L2TP_IP = 2'h2,
        HDR_MEF = 2'h3
    } header_kind_t;

    typedef enum logic [1:0] {
        IF_FRAMED = 2'h0,
        IF_UNFRAMED = 2'h1,
        IF_HIGH_SPEED = 2'h2
    } iface_t;

    localparam int JBUF_UNIT_FRAMED_US = 500;
    localparam logic [12:0] JBUF_UNIT_UNFRAMED_BITS = 13'h0400;
    localparam logic [12:0] JBUF_UNIT_HS_BITS = 13'h1000;
    localparam logic [4:0] TS_UNSTRUCTURED = 5'h1f;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

endpackage

// ---- rtl/bundle_word_ram.sv ----
// Holds one column of the bundle table: one 32-bit word for each bundle
// Assumes one write and two independent reads per cycle, all registered
`timescale 1ns/1ps
module bundle_word_ram #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clock,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [AW-1:0] rdAddrA,
    output logic [31:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [31:0] rdDataB
);

    // No reset on the array: contents are undefined until software fills them
    logic [31:0] mem [DEPTH];

    // Write port and two registered read ports
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end

endmodule

// ---- rtl/aal1_bundle_config_table.sv ----
// Bundle configuration table: host port plus decoded fields for the engine
// Assumes host strobes and engine lookups come from logic on this clock
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module aal1_bundle_config_table
    import bundle_cfg_pkg::*;
#(
    parameter int NUM_BUNDLES = BUNDLES,
    parameter int NUM_WORDS = WORDS_PER_BUNDLE
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic [BUNDLE_W-1:0] lookupBundle,
    input wire logic [1:0] lookupIface,
    output logic [31:0] rxBundleIdent,
    output logic [9:0] jitterBufSize,
    output logic [12:0] jitterUnitBits,
    output logic jitterUnitIsTime,
    output logic [1:0] payloadKind,
    output logic isAal1,
    output logic payloadKindReserved,
    output logic transmit_rtp_present,
    output logic controlWordPresent,
    output logic [1:0] destination,
    output logic toEthernet,
    output logic toProcessor,
    output logic toCrossConnect,
    output logic destReserved,
    output logic [6:0] maxLostPackets,
    output logic [4:0] timeslot_count_minus_one,
    output logic [5:0] timeslotCount,
    output logic discardSanityFail,
    output logic [1:0] headerKind,
    output logic setRBit
);

    // ------------------------------------------------------------
    // Host address decode
    // ------------------------------------------------------------
    // Offset within the table window, split into word column and bundle
    wire [15:0] tableOfs = regAddr - TABLE_BASE;
    wire inTable = (regAddr >= TABLE_BASE) && (tableOfs < TABLE_SPAN);
    wire aligned = (regAddr[1:0] == 2'h0);
    wire [WORD_SEL_W-1:0] wordSel = tableOfs[WORD_SEL_LSB +: WORD_SEL_W];
    wire [BUNDLE_W-1:0] hostBundle = tableOfs[BUNDLE_LSB +: BUNDLE_W];
    // Gaps between the 64-word columns are not part of the table
    // Nine bits wide so a full 256-byte column does not wrap to zero
    wire inColumn = ({1'b0, tableOfs[7:0]} < 9'(NUM_BUNDLES * 4));
    wire hit = inTable && aligned && inColumn;

    // ------------------------------------------------------------
    // Word columns
    // ------------------------------------------------------------
    logic [31:0] hostWord [NUM_WORDS];
    logic [31:0] engWord [NUM_WORDS];

    // One RAM per 32-bit word; five columns make the 160-bit entry
    generate
        for (genvar k = 0; k < NUM_WORDS; k++) begin : g_col
            wire colWrite = regWrite && hit && (wordSel == WORD_SEL_W'(k));
            bundle_word_ram #(
                .DEPTH(NUM_BUNDLES),
                .AW(BUNDLE_W)
            ) u_ram (
                .clock(clock),
                .wrEn(colWrite),
                .wrAddr(hostBundle),
                .wrData(regWrData),
                .rdAddrA(hostBundle),
                .rdDataA(hostWord[k]),
                .rdAddrB(lookupBundle),
                .rdDataB(engWord[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------
    // Read qualifiers delayed to line up with the registered RAM output
    logic readHit_q;
    logic readHit_d;
    logic [WORD_SEL_W-1:0] readSel_q;
    logic [WORD_SEL_W-1:0] readSel_d;

    assign readHit_d = regRead && hit;
    assign readSel_d = wordSel;

    // Only the qualifiers are reset; the table itself keeps no reset value
    always_ff @(posedge clock) begin
        if (rst) begin
            readHit_q <= 1'b0;
            readSel_q <= '0;
        end else begin
            readHit_q <= readHit_d;
            readSel_q <= readSel_d;
        end
    end

    // Reads return stored value only, with nothing cleared on read
    wire [31:0] selWord = (readSel_q < WORD_SEL_W'(NUM_WORDS)) ? hostWord[readSel_q] : UNMAPPED_READ;
    assign regRdData = readHit_q ? selWord : UNMAPPED_READ;

    // ------------------------------------------------------------
    // Engine field decode
    // ------------------------------------------------------------
    // Engine lookup result stands one cycle after lookupBundle is presented
    wire [31:0] identWord = engWord[IDENT_WORD_OFS[WORD_SEL_LSB +: WORD_SEL_W]];
    wire [31:0] ctrlWord = engWord[CONTROL_WORD_OFS[WORD_SEL_LSB +: WORD_SEL_W]];

    // Receive identifier is the whole first word
    assign rxBundleIdent = identWord;

    // Jitter buffer size and its unit for the selected interface type
    assign jitterBufSize = ctrlWord[JBUF_MSB:JBUF_LSB];
    assign jitterUnitIsTime = (lookupIface == IF_FRAMED);
    assign jitterUnitBits = (lookupIface == IF_HIGH_SPEED) ? JBUF_UNIT_HS_BITS :
                            (lookupIface == IF_UNFRAMED) ? JBUF_UNIT_UNFRAMED_BITS : 13'h0000;

    // Payload kind; reserved code is flagged rather than trusted
    assign payloadKind = ctrlWord[PTYPE_MSB:PTYPE_LSB];
    assign isAal1 = (payloadKind == PAY_AAL1);
    assign payloadKindReserved = (payloadKind == PAY_RSVD);

    // Transmit header options
    assign transmit_rtp_present = ctrlWord[RTP_BIT];
    assign controlWordPresent = ctrlWord[CW_BIT];
    assign headerKind = ctrlWord[HDR_MSB:HDR_LSB];
    assign setRBit = ctrlWord[RBIT_BIT];

    // Destination one-hots for the packet router
    assign destination = ctrlWord[DEST_MSB:DEST_LSB];
    assign toEthernet = (destination == DST_ETH);
    assign toProcessor = (destination == DST_CPU);
    assign toCrossConnect = (destination == DST_TDM);
    assign destReserved = (destination == DST_RSVD);

    // Receive loss handling and timeslot count
    assign maxLostPackets = ctrlWord[LOST_MSB:LOST_LSB];
    assign timeslot_count_minus_one = ctrlWord[TS_MSB:TS_LSB];
    assign timeslotCount = {1'b0, timeslot_count_minus_one} + 6'h01;

    // Keep bit set means sanity failures pass; the drop is the default sense for the AAL1 kind only
    assign discardSanityFail = isAal1 && !ctrlWord[KEEP_BAD_BIT];

endmodule

// ---- sim/bundle_cfg_asserts.sv ----
// Checker for the bundle table: host read timing and field decoding
// Assumes a bind onto the table's top module; sees its ports only
`timescale 1ns/1ps
module bundle_cfg_asserts
    import bundle_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    input wire logic [1:0] lookupIface,
    input wire logic [12:0] jitterUnitBits,
    input wire logic jitterUnitIsTime,
    input wire logic [1:0] payloadKind,
    input wire logic isAal1,
    input wire logic payloadKindReserved,
    input wire logic [1:0] destination,
    input wire logic toCrossConnect,
    input wire logic toEthernet,
    input wire logic [4:0] timeslot_count_minus_one,
    input wire logic [5:0] timeslotCount,
    input wire logic discardSanityFail
);
    // ----------------------------------------
    // Decode and properties
    // ----------------------------------------
    // Aligned hit in the five columns; field checks key on values so unwritten words stay vacuous
    wire hit = regAddr >= TABLE_BASE && regAddr < TABLE_BASE + TABLE_SPAN && regAddr[1:0] == 2'h0;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_idle_read_zero: assert property (!$past(regRead) |-> regRdData == UNMAPPED_READ)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ($past(regRead) && !$past(hit) |-> regRdData == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_write_readback: assert property (regWrite && hit ##1 regRead && $stable(regAddr) |=>
        regRdData == $past(regWrData, 2)) else $error("read after write lost data");
    a_kind_decode: assert property (payloadKind == 2'h1 |-> isAal1 && !payloadKindReserved)
        else $error("payload kind decode wrong");
    a_kind_reserved: assert property (payloadKind == 2'h2 |-> payloadKindReserved && !isAal1)
        else $error("reserved payload kind not flagged");
    a_dest_decode: assert property (destination == 2'h3 |-> toCrossConnect && !toEthernet)
        else $error("destination decode wrong");
    a_ts_plus_one: assert property (timeslot_count_minus_one == 5'h1f |-> timeslotCount == 6'h20)
        else $error("timeslot count not one more");
    a_discard_gate: assert property (discardSanityFail |-> isAal1)
        else $error("discard outside AAL1 kind");
    a_unit_bits: assert property (lookupIface == 2'h2 |-> !jitterUnitIsTime && jitterUnitBits == JBUF_UNIT_HS_BITS)
        else $error("high speed jitter unit wrong");
endmodule

bind aal1_bundle_config_table bundle_cfg_asserts bundle_cfg_asserts_i (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .lookupIface(lookupIface),
    .jitterUnitBits(jitterUnitBits), .jitterUnitIsTime(jitterUnitIsTime), .payloadKind(payloadKind), .isAal1(isAal1),
    .payloadKindReserved(payloadKindReserved), .destination(destination), .toCrossConnect(toCrossConnect),
    .toEthernet(toEthernet), .timeslot_count_minus_one(timeslot_count_minus_one), .timeslotCount(timeslotCount),
    .discardSanityFail(discardSanityFail));

// ---- sim/tb_top.sv ----
// Bench for the bundle table: word map, refused accesses, field lookups
// Assumes the checker binds itself; the bench drives every input
`timescale 1ns/1ps
module tb_top
    import bundle_cfg_pkg::*;
;
    // ----------------------------------------
    // Stimulus, checks and verdict
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regAddr = 16'h0;
    logic [31:0] regWrData = 32'h0;
    logic [5:0] lookupBundle = 6'h0;
    logic [1:0] lookupIface = 2'h0;
    logic [31:0] regRdData, rxBundleIdent;
    logic [12:0] jitterUnitBits;
    logic [9:0] jitterBufSize;
    logic [6:0] maxLostPackets;
    logic [5:0] timeslotCount;
    logic [4:0] timeslot_count_minus_one;
    logic [1:0] payloadKind, destination, headerKind;
    logic jitterUnitIsTime, isAal1, payloadKindReserved, transmit_rtp_present, controlWordPresent;
    logic toEthernet, toProcessor, toCrossConnect, destReserved, discardSanityFail, setRBit;
    logic [15:0] badAddr [3] = '{16'h8500, 16'h7ffc, 16'h8002};
    logic [13:0] unitExp [3] = '{{1'b1, 13'h0}, {1'b0, JBUF_UNIT_UNFRAMED_BITS}, {1'b0, JBUF_UNIT_HS_BITS}};
    int errors = 0;
    int tests_run = 0;
    aal1_bundle_config_table aal1_bundle_config_table_i (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .lookupBundle(lookupBundle), .lookupIface(lookupIface), .rxBundleIdent(rxBundleIdent),
        .jitterBufSize(jitterBufSize), .jitterUnitBits(jitterUnitBits), .jitterUnitIsTime(jitterUnitIsTime),
        .payloadKind(payloadKind), .isAal1(isAal1), .payloadKindReserved(payloadKindReserved),
        .transmit_rtp_present(transmit_rtp_present), .controlWordPresent(controlWordPresent),
        .destination(destination), .toEthernet(toEthernet), .toProcessor(toProcessor),
        .toCrossConnect(toCrossConnect), .destReserved(destReserved), .maxLostPackets(maxLostPackets),
        .timeslot_count_minus_one(timeslot_count_minus_one), .timeslotCount(timeslotCount),
        .discardSanityFail(discardSanityFail), .headerKind(headerKind), .setRBit(setRBit));
    // Compare, count, report
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Write strobe is left high so a following read can come with no gap
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regRead <= 1'b0;
        regAddr <= a;
        regWrData <= d;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #4 clock = ~clock;
    end
    // Watchdog, far beyond the 134 or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end
    initial begin : main_seq
        logic [31:0] v, e, ctrl;
        logic [15:0] a;
        logic [1:0] c;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1 chk("rdata_reset", regRdData, 32'h0);
        // Pass 0 writes then reads back at once, pass 1 rereads everything
        for (int p = 0; p < 2; p++) begin
            for (int n = 0; n < BUNDLES; n += 21) begin
                for (int k = 0; k < WORDS_PER_BUNDLE; k++) begin
                    a = TABLE_BASE + WORD_STRIDE * 16'(k) + 16'(4 * n);
                    e = {8'(k), 8'(n), 16'h5ac3};
                    if (p == 0) wr(a, e);
                    rd(a, v);
                    chk("table_word", v, e);
                end
            end
        end
        // Past the end, below the base, misaligned: ignored and read as zero
        foreach (badAddr[j]) begin
            wr(badAddr[j], 32'hffffffff);
            rd(badAddr[j], v);
            chk("unmapped", v, UNMAPPED_READ);
        end
        rd(TABLE_BASE, v);
        chk("no_alias", v, 32'h00005ac3);
        // Every code of each two-bit field, one bundle each
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            ctrl = {10'h3fb - 10'(c), c, c[0], c[1], c, 7'h7f - 7'(c), 5'h1f - 5'(c), c[1], c, c[0]};
            wr(16'h8114 + 16'(4 * i), ctrl);
            wr(16'h8014 + 16'(4 * i), ~ctrl);
            @(posedge clock);
            regWrite <= 1'b0;
            lookupBundle <= 6'(5 + i);
            @(posedge clock);
            #1 chk("ident", rxBundleIdent, ~ctrl);
            chk("jbuf", jitterBufSize, 10'h3fb - 10'(c));
            chk("kind", {payloadKindReserved, isAal1, payloadKind}, {c == 2'h2, c == 2'h1, c});
            chk("flags", {transmit_rtp_present, controlWordPresent, setRBit}, {c[0], c[1], c[0]});
            chk("discard", discardSanityFail, c == 2'h1);
            chk("dest", {destReserved, toCrossConnect, toProcessor, toEthernet, destination},
                {c == 2'h0, c == 2'h3, c == 2'h2, c == 2'h1, c});
            chk("lost", maxLostPackets, 7'h7f - 7'(c));
            chk("ts", {timeslotCount, timeslot_count_minus_one}, {6'h20 - 6'(c), 5'h1f - 5'(c)});
            chk("hdr", headerKind, c);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            lookupIface <= i[1:0];
            #1 chk("jitter_unit", {jitterUnitIsTime, jitterUnitBits}, unitExp[i]);
        end
        test_done();
    end
endmodule
